/* core/bbar_pkg.sv */
// Shared constants, types and helpers for the bit-band address remapper.
package bbar_pkg;

  // ************************************************************
  // Address map
  // ************************************************************

  // Base of each 1 MB bit-band region.
  localparam logic [31:0] BBAR_SRAM_BB_BASE = 32'h2000_0000;
  localparam logic [31:0] BBAR_PERI_BB_BASE = 32'h4000_0000;

  // Upper address bits that select each 32 MB alias window.
  localparam int          BBAR_TAG_MSB        = 31;
  localparam int          BBAR_TAG_LSB        = 25;
  localparam logic [6:0]  BBAR_SRAM_ALIAS_TAG = 7'h11;
  localparam logic [6:0]  BBAR_PERI_ALIAS_TAG = 7'h21;

  // Alias address fields: byte offset into the region and bit number.
  localparam int          BBAR_BYTE_OFF_MSB = 24;
  localparam int          BBAR_BYTE_OFF_LSB = 5;
  localparam int          BBAR_BITNUM_MSB   = 4;
  localparam int          BBAR_BITNUM_LSB   = 2;

  // ************************************************************
  // Access sizes and states
  // ************************************************************

  localparam logic [1:0]  BBAR_SIZE_BYTE = 2'h0;
  localparam logic [1:0]  BBAR_SIZE_HALF = 2'h1;
  localparam logic [1:0]  BBAR_SIZE_WORD = 2'h2;

  typedef enum logic [3:0] {
    BBAR_ST_IDLE   = 4'h1,
    BBAR_ST_PASS   = 4'h2,
    BBAR_ST_RMW_RD = 4'h4,
    BBAR_ST_RMW_WR = 4'h8
  } bbar_state_t;

  // Align a byte address down to the natural boundary of the access size.
  function automatic logic [31:0] bbar_align(input logic [31:0] a, input logic [1:0] s);
    logic [31:0] r;
    r = a;
    if (s == BBAR_SIZE_HALF) begin
      r = {a[31:1], 1'h0};
    end else if (s == BBAR_SIZE_WORD) begin
      r = {a[31:2], 2'h0};
    end
    return r;
  endfunction

  // Bit position on the 32-bit data bus for a bit of a byte address.
  // Little-endian: byte lane equals the low two address bits.
  function automatic logic [4:0] bbar_bus_bit(input logic [31:0] a, input logic [2:0] b);
    return {a[1:0], b};
  endfunction

endpackage

/* core/bbar_xlate.sv */
// Alias window decoder and alias-to-bit-band address translator.
`timescale 1ns/1ns
module bbar_xlate
  import bbar_pkg::*;
(
  input  wire logic [31:0] addr,
  input  wire logic        instr,
  output logic             sram_alias,
  output logic             peri_alias,
  output logic             remap,
  output logic             refuse,
  output logic [31:0]      tgt_addr,
  output logic [4:0]       bus_bit
);

  logic [31:0] base;

  // Window decode; fetches in the SRAM alias pass through, in the peripheral alias refuse.
  always_comb begin
    sram_alias = (addr[BBAR_TAG_MSB:BBAR_TAG_LSB] == BBAR_SRAM_ALIAS_TAG);
    peri_alias = (addr[BBAR_TAG_MSB:BBAR_TAG_LSB] == BBAR_PERI_ALIAS_TAG);
    remap      = (sram_alias || peri_alias) && !instr;
    refuse     = peri_alias && instr;
    base       = sram_alias ? BBAR_SRAM_BB_BASE : BBAR_PERI_BB_BASE;
  end

  // Inverse of word offset = byte offset * 32 + bit * 4.
  always_comb begin
    tgt_addr = base | {12'h000, addr[BBAR_BYTE_OFF_MSB:BBAR_BYTE_OFF_LSB]};
    bus_bit  = bbar_bus_bit(tgt_addr, addr[BBAR_BITNUM_MSB:BBAR_BITNUM_LSB]);
  end

endmodule

/* core/bbar_remap.sv */
// Top of the bit-band address remapper between bus master and memory slaves.
//
// Operation
// - Each alias word maps to one bit.
// - Both 32 MB alias windows map onto 1 MB regions.
// - Downstream access keeps the alias access size.
// - Direct SRAM bit-band accesses pass as normal.
// - SRAM alias data remapped, fetches passed unchanged.
// - Direct peripheral bit-band accesses pass as normal.
// - Peripheral alias data remapped, fetches refused.
// - Word offset is byte*32 plus bit*4.
// - Alias address inverted to byte and bit.
// - Target bit number ranges zero to seven.
// - Write data bit zero sets target bit.
// - Write data bits 31:1 are ignored.
// - Alias read returns zero or one only.
// - Multi-byte data is little-endian on lanes.
`timescale 1ns/1ns
module bbar_remap
  import bbar_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        up_req,
  input  wire logic [31:0] up_addr,
  input  wire logic        up_write,
  input  wire logic [1:0]  up_size,
  input  wire logic [31:0] up_wdata,
  input  wire logic        up_instr,
  output logic             up_ready,
  output logic             up_ack,
  output logic             up_err,
  output logic [31:0]      up_rdata,
  output logic             dn_req,
  output logic [31:0]      dn_addr,
  output logic             dn_write,
  output logic [1:0]       dn_size,
  output logic [31:0]      dn_wdata,
  output logic             dn_instr,
  input  wire logic        dn_ack,
  input  wire logic        dn_err,
  input  wire logic [31:0] dn_rdata
);

  // ************************************************************
  // State
  // ************************************************************

  typedef struct packed {
    bbar_state_t state;
    logic        up_ready;
    logic        up_ack;
    logic        up_err;
    logic [31:0] up_rdata;
    logic        dn_req;
    logic [31:0] dn_addr;
    logic        dn_write;
    logic [1:0]  dn_size;
    logic [31:0] dn_wdata;
    logic        dn_instr;
    logic        alias_wr;
    logic        wbit;
    logic [4:0]  bus_bit;
  } bbar_regs_t;

  bbar_regs_t r_ff;
  bbar_regs_t nxt_r;

  logic        sram_alias;
  logic        peri_alias;
  logic        remap;
  logic        refuse;
  logic [31:0] tgt_addr;
  logic [4:0]  bus_bit;
  logic        accept;

  bbar_xlate u_xlate (
    .addr       (up_addr),
    .instr      (up_instr),
    .sram_alias (sram_alias),
    .peri_alias (peri_alias),
    .remap      (remap),
    .refuse     (refuse),
    .tgt_addr   (tgt_addr),
    .bus_bit    (bus_bit)
  );

  // A request is taken only while the bridge reports itself ready.
  assign accept = up_req && r_ff.up_ready;

  // ************************************************************
  // Next-state logic
  // ************************************************************

  // One transaction at a time keeps the read-modify-write atomic toward the slave.
  always_comb begin
    nxt_r        = r_ff;
    nxt_r.up_ack = 1'h0;
    nxt_r.up_err = 1'h0;
    unique case (r_ff.state)
      BBAR_ST_IDLE: begin
        if (accept && refuse) begin
          nxt_r.up_ack   = 1'h1;
          nxt_r.up_err   = 1'h1;
          nxt_r.up_rdata = 32'h0000_0000;
        end else if (accept && remap) begin
          nxt_r.state    = BBAR_ST_RMW_RD;
          nxt_r.dn_req   = 1'h1;
          nxt_r.dn_addr  = bbar_align(tgt_addr, up_size);
          nxt_r.dn_write = 1'h0;
          nxt_r.dn_size  = up_size;
          nxt_r.dn_wdata = 32'h0000_0000;
          nxt_r.dn_instr = 1'h0;
          nxt_r.alias_wr = up_write;
          nxt_r.wbit     = up_wdata[0];
          nxt_r.bus_bit  = bus_bit;
        end else if (accept) begin
          nxt_r.state    = BBAR_ST_PASS;
          nxt_r.dn_req   = 1'h1;
          nxt_r.dn_addr  = up_addr;
          nxt_r.dn_write = up_write;
          nxt_r.dn_size  = up_size;
          nxt_r.dn_wdata = up_wdata;
          nxt_r.dn_instr = up_instr;
        end
      end
      BBAR_ST_PASS: begin
        if (dn_ack) begin
          nxt_r.state    = BBAR_ST_IDLE;
          nxt_r.dn_req   = 1'h0;
          nxt_r.up_ack   = 1'h1;
          nxt_r.up_err   = dn_err;
          nxt_r.up_rdata = dn_rdata;
        end
      end
      BBAR_ST_RMW_RD: begin
        if (dn_ack && !dn_err && r_ff.alias_wr) begin
          // Keep every other bit of the read data, replace only the target bit.
          nxt_r.state    = BBAR_ST_RMW_WR;
          nxt_r.dn_write = 1'h1;
          nxt_r.dn_wdata = dn_rdata;
          nxt_r.dn_wdata[r_ff.bus_bit] = r_ff.wbit;
        end else if (dn_ack) begin
          nxt_r.state    = BBAR_ST_IDLE;
          nxt_r.dn_req   = 1'h0;
          nxt_r.up_ack   = 1'h1;
          nxt_r.up_err   = dn_err;
          nxt_r.up_rdata = {31'h0000_0000, dn_rdata[r_ff.bus_bit] && !dn_err};
        end
      end
      BBAR_ST_RMW_WR: begin
        if (dn_ack) begin
          nxt_r.state    = BBAR_ST_IDLE;
          nxt_r.dn_req   = 1'h0;
          nxt_r.up_ack   = 1'h1;
          nxt_r.up_err   = dn_err;
          nxt_r.up_rdata = 32'h0000_0000;
        end
      end
    endcase
    nxt_r.up_ready = (nxt_r.state == BBAR_ST_IDLE);
  end

  // ************************************************************
  // Registers
  // ************************************************************

  // Synchronous reset to an idle, ready bridge with nothing on the downstream bus.
  always_ff @(posedge clock) begin
    if (reset) begin
      r_ff          <= '0;
      r_ff.state    <= BBAR_ST_IDLE;
      r_ff.up_ready <= 1'h1;
    end else begin
      r_ff <= nxt_r;
    end
  end

  assign up_ready = r_ff.up_ready;
  assign up_ack   = r_ff.up_ack;
  assign up_err   = r_ff.up_err;
  assign up_rdata = r_ff.up_rdata;
  assign dn_req   = r_ff.dn_req;
  assign dn_addr  = r_ff.dn_addr;
  assign dn_write = r_ff.dn_write;
  assign dn_size  = r_ff.dn_size;
  assign dn_wdata = r_ff.dn_wdata;
  assign dn_instr = r_ff.dn_instr;

  // ************************************************************
  // Assertions
  // ************************************************************

  // A refused fetch answers with an error on the next edge and never reaches the slave.
  property p_fetch_refused;
    @(posedge clock) disable iff (reset)
      accept && up_instr && peri_alias |=> up_ack && up_err && !dn_req;
  endproperty
  a_fetch_refused: assert property (p_fetch_refused) else $error("peri fetch not refused");

  // An alias access starts with a read of the same size at the translated byte address aligned down to that size.
  property p_alias_read_first;
    @(posedge clock) disable iff (reset)
      accept && remap |=> dn_req && !dn_write && dn_size == $past(up_size)
        && dn_addr == bbar_align($past(tgt_addr), $past(up_size));
  endproperty
  a_alias_read_first: assert property (p_alias_read_first) else $error("bad alias read");

  // Explicit translation check for the SRAM window.
  property p_sram_xlate;
    @(posedge clock) disable iff (reset)
      accept && sram_alias && !up_instr |=> dn_addr[31:20] == 12'h200
        && dn_addr[19:2] == $past(up_addr[24:7]);
  endproperty
  a_sram_xlate: assert property (p_sram_xlate) else $error("bad sram translation");

  // Accesses outside the alias windows go out unchanged.
  property p_pass_through;
    @(posedge clock) disable iff (reset)
      accept && !remap && !refuse |=> dn_req && dn_addr == $past(up_addr)
        && dn_write == $past(up_write) && dn_size == $past(up_size)
        && dn_wdata == $past(up_wdata) && dn_instr == $past(up_instr);
  endproperty
  a_pass_through: assert property (p_pass_through) else $error("pass-through altered");

  // An alias write rewrites the read data with only the target bit taken from bit zero.
  property p_rmw_write;
    @(posedge clock) disable iff (reset)
      r_ff.state == BBAR_ST_RMW_RD && dn_ack && !dn_err && r_ff.alias_wr |=> dn_write
        && dn_wdata[r_ff.bus_bit] == r_ff.wbit
        && ((dn_wdata ^ $past(dn_rdata)) & ~(32'h0000_0001 << r_ff.bus_bit)) == 32'h0;
  endproperty
  a_rmw_write: assert property (p_rmw_write) else $error("bad modify-write data");

  // The stored write bit depends only on data bit zero.
  property p_wbit_src;
    @(posedge clock) disable iff (reset)
      accept && remap && up_write |=> r_ff.wbit == $past(up_wdata[0]);
  endproperty
  a_wbit_src: assert property (p_wbit_src) else $error("write bit not from bit 0");

  // An alias read returns the single target bit with upper bits zero.
  property p_alias_read_data;
    @(posedge clock) disable iff (reset)
      r_ff.state == BBAR_ST_RMW_RD && dn_ack && !dn_err && !r_ff.alias_wr |=> up_ack
        && up_rdata[31:1] == 31'h0 && up_rdata[0] == $past(dn_rdata[r_ff.bus_bit]);
  endproperty
  a_alias_read_data: assert property (p_alias_read_data) else $error("bad alias read data");

  // The target bit sits in the lane of its byte address.
  property p_lane;
    @(posedge clock) disable iff (reset)
      accept && remap |=> r_ff.bus_bit[4:3] == $past(tgt_addr[1:0])
        && r_ff.bus_bit[2:0] == $past(up_addr[4:2]);
  endproperty
  a_lane: assert property (p_lane) else $error("bad byte lane");

  // A completed write cycle returns to ready in one edge.
  property p_wr_done;
    @(posedge clock) disable iff (reset)
      r_ff.state == BBAR_ST_RMW_WR && dn_ack |=> up_ack && up_ready && !dn_req;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("write phase did not finish");

endmodule

/* verification/bbar_slave_model.sv */
// Downstream memory slave model with random wait states and forced errors.
`timescale 1ns/1ns
module bbar_slave_model
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        dn_req,
  input  wire logic [31:0] dn_addr,
  input  wire logic        dn_write,
  input  wire logic [1:0]  dn_size,
  input  wire logic [31:0] dn_wdata,
  input  wire logic        dn_instr,
  input  wire logic        fail,
  output logic             dn_ack,
  output logic             dn_err,
  output logic [31:0]      dn_rdata
);
  logic [31:0] mem [logic [29:0]];
  logic [31:0] m;
  logic [31:0] w;
  int          wait_n;

  // Byte lanes of one access, little-endian by low address bits.
  function automatic logic [31:0] lanes(input logic [1:0] s, input logic [1:0] a);
    if (s == 2'h2) begin
      return 32'hffff_ffff;
    end
    return (s == 2'h1) ? (32'hffff << (a[1] * 16)) : (32'hff << (a * 8));
  endfunction

  // Answer after zero to two idle cycles; read data turns to junk between
  // answers so a stale value is never mistaken for a fresh one.
  always @(posedge clock) begin
    if (reset) begin
      dn_ack   <= 1'b0;
      dn_err   <= 1'b0;
      dn_rdata <= 32'h0;
      wait_n   <= 0;
    end else if (dn_ack) begin
      dn_ack   <= 1'b0;
      dn_err   <= 1'b0;
      dn_rdata <= ~dn_rdata;
      wait_n   <= $urandom_range(2);
    end else if (dn_req && wait_n != 0) begin
      wait_n   <= wait_n - 1;
      dn_rdata <= ~dn_rdata;
    end else if (dn_req) begin
      m = lanes(dn_size, dn_addr[1:0]);
      w = mem.exists(dn_addr[31:2]) ? mem[dn_addr[31:2]] : 32'h0;
      dn_ack   <= 1'b1;
      dn_err   <= fail;
      dn_rdata <= w;
      if (dn_write && !fail) begin
        mem[dn_addr[31:2]] = (w & ~m) | (dn_wdata & m);
      end
    end
  end
endmodule

/* verification/bbar_remap_tb_top.sv */
// Self-checking bench for the bit-band address remapper.
`timescale 1ns/1ns
module bbar_remap_tb_top;
  import bbar_pkg::*;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        up_req = 1'b0;
  logic [31:0] up_addr = 32'h0;
  logic        up_write = 1'b0;
  logic [1:0]  up_size = 2'h0;
  logic [31:0] up_wdata = 32'h0;
  logic        up_instr = 1'b0;
  logic        fail = 1'b0;
  logic        up_ready, up_ack, up_err, dn_req, dn_write, dn_instr, dn_ack, dn_err;
  logic [31:0] up_rdata, dn_addr, dn_wdata, dn_rdata, dn_a, a, d, t, rd;
  logic [1:0]  dn_size, dn_s, s;
  logic [19:0] off;
  logic [7:0]  v;
  logic [7:0]  sh [logic [31:0]];
  logic        dn_i, er;
  int          n_fail = 0, compares = 0, cycles = 0, n_dn = 0, n0, b, k;

  bbar_remap DUT (.clock(clock), .reset(reset), .up_req(up_req), .up_addr(up_addr),
    .up_write(up_write), .up_size(up_size), .up_wdata(up_wdata), .up_instr(up_instr),
    .up_ready(up_ready), .up_ack(up_ack), .up_err(up_err), .up_rdata(up_rdata),
    .dn_req(dn_req), .dn_addr(dn_addr), .dn_write(dn_write), .dn_size(dn_size),
    .dn_wdata(dn_wdata), .dn_instr(dn_instr), .dn_ack(dn_ack), .dn_err(dn_err),
    .dn_rdata(dn_rdata));

  bbar_slave_model slave (.clock(clock), .reset(reset), .dn_req(dn_req),
    .dn_addr(dn_addr), .dn_write(dn_write), .dn_size(dn_size), .dn_wdata(dn_wdata),
    .dn_instr(dn_instr), .fail(fail), .dn_ack(dn_ack), .dn_err(dn_err),
    .dn_rdata(dn_rdata));

  // 250 MHz clock.
  always #2 clock = ~clock;

  // Record each downstream answer and cut a hang short.
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (dn_req && dn_ack) begin
      n_dn <= n_dn + 1;
      dn_a <= dn_addr;
      dn_s <= dn_size;
      dn_i <= dn_instr;
    end
    if (cycles == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ************************************************************
  // Tasks and reference functions
  // ************************************************************

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One upstream transfer; request held until taken, then wait for the answer.
  task automatic xfer(input logic [31:0] xa, input logic w, input logic [1:0] xs,
                      input logic [31:0] xd, input logic f);
    int n;
    n = 0;
    up_addr = xa;
    up_write = w;
    up_size = xs;
    up_wdata = xd;
    up_instr = f;
    up_req = 1'b1;
    // Ready is looked at after it has settled; the next edge then takes the request.
    while (up_ready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    #1 up_req = 1'b0;
    while (up_ack !== 1'b1 && n < 100) begin
      n++;
      @(posedge clock);
      #1;
    end
    if (n >= 100) begin
      n_fail++;
    end
    rd = up_rdata;
    er = up_err;
    // Let one edge pass so a following call never raises up_req in the step that lowered it.
    @(posedge clock);
    #1;
  endtask

  // Shadow byte, zero where never written.
  function automatic logic [7:0] gb(input logic [31:0] x);
    return sh.exists(x) ? sh[x] : 8'h0;
  endfunction

  // Expected word, lowest address in the lowest lane.
  function automatic logic [31:0] word(input logic [31:0] x);
    return {gb({x[31:2], 2'h3}), gb({x[31:2], 2'h2}), gb({x[31:2], 2'h1}),
            gb({x[31:2], 2'h0})};
  endfunction

  // ************************************************************
  // Main sequence
  // ************************************************************

  initial begin
    void'($urandom(32'had6a0889));
    repeat (3) @(posedge clock);
    #1;
    check({up_ready, dn_req, up_ack}, 32'h4);
    reset = 1'b0;
    for (int i = 0; i < 300; i++) begin
      k = (i < 3) ? 1 : $urandom_range(1);
      s = 2'($urandom_range(2));
      d = $urandom;
      if (k == 0) begin
        // Direct access to a bit-band region or an unrelated region.
        k = $urandom_range(2);
        t = (k == 0) ? 32'h2000_0000 : (k == 1) ? 32'h4000_0000 : 32'h6000_0010;
        a = t | (32'($urandom_range(63)) & ~((32'h1 << s) - 32'h1));
        xfer(a, 1'b1, s, d, 1'b0);
        for (int j = 0; j < (1 << s); j++) begin
          sh[a + j] = d[8 * ((a + j) % 4) +: 8];
        end
        check(dn_a, a);
        check(32'(dn_s), 32'(s));
        xfer(a, 1'b0, s, 32'h0, 1'b0);
        check(rd, word(a));
      end else begin
        // Alias write of one bit, then alias read of the same bit.
        off = (i < 3) ? ((i == 2) ? 20'h0 : 20'hfffff) : 20'($urandom_range(63));
        b = (i < 3) ? ((i == 0) ? 0 : 7) : $urandom_range(7);
        k = (i < 3) ? 0 : $urandom_range(1);
        t = ((k == 0) ? 32'h2000_0000 : 32'h4000_0000) | {12'h0, off};
        a = ((k == 0) ? 32'h2200_0000 : 32'h4200_0000) + off * 32 + b * 4;
        xfer(a, 1'b1, s, d, 1'b0);
        v = gb(t);
        v[b] = d[0];
        sh[t] = v;
        check(dn_a, t & ~((32'h1 << s) - 32'h1));
        check(32'(dn_s), 32'(s));
        xfer(a, 1'b0, s, ~d, 1'b0);
        check(rd, {31'h0, v[b]});
        check(32'(er), 32'h0);
      end
    end
    // Fetches: refused in the peripheral alias, unchanged in the SRAM alias.
    n0 = n_dn;
    xfer(32'h4200_0040, 1'b0, 2'h2, 32'h0, 1'b1);
    check({31'h0, er}, 32'h1);
    check(32'(n_dn), 32'(n0));
    xfer(32'h2200_0040, 1'b0, 2'h2, 32'h0, 1'b1);
    check({dn_a[31:1], dn_i}, 32'h2200_0041);
    // A failing underlying read makes the alias read an error returning zero.
    fail = 1'b1;
    xfer(32'h2200_0044, 1'b0, 2'h2, 32'h0, 1'b0);
    fail = 1'b0;
    check({rd[31:1], er}, 32'h1);
    end_of_test();
  end
endmodule
